// *** core/qbp_pkg.sv ***
/*
  Constants shared by the quasi-bidirectional port block: widths, alternate
  function bit positions, reset values, timing figures and the latch update
  operations.
  Assumes the core clock and the oscillator rates are given in hertz.
*/
`default_nettype none

package qbp_pkg;

  // ----------------------------------------------------------------
  // Port widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned P3_W = 8;
  localparam int unsigned P4_W = 2;
  localparam int unsigned BUS_W = 8;
  localparam logic [P3_W-1:0] P3_LATCH_RST = 8'hff;
  localparam logic [P4_W-1:0] P4_LATCH_RST = 2'h3;
  localparam logic [BUS_W-1:0] BUS_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Alternate function bit positions
  // ----------------------------------------------------------------
  localparam int unsigned P3_SER_RX_BIT = 0;
  localparam int unsigned P3_SER_TX_BIT = 1;
  localparam int unsigned P3_IRQ0_BIT = 2;
  localparam int unsigned P3_IRQ1_BIT = 3;
  localparam int unsigned P3_TMR0_BIT = 4;
  localparam int unsigned P3_TMR1_BIT = 5;
  localparam int unsigned P3_EXT_WR_BIT = 6;
  localparam int unsigned P4_CAN_TX_BIT = 0;
  localparam int unsigned P4_CAN_RX_BIT = 1;

  // ----------------------------------------------------------------
  // Timing figures
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 20_000_000;
  localparam longint unsigned OSC_HZ = 20_000_000;
  localparam longint unsigned BOOST_OSC_PERIODS = 2;
  localparam longint unsigned RESET_MACHINE_CYCLES = 2;
  localparam longint unsigned OSC_PER_MACHINE_CYCLE = 12;
  // Least times: round up, at least one cycle
  localparam longint unsigned BOOST_CYC_RAW = (BOOST_OSC_PERIODS * CLK_HZ + OSC_HZ - 1) / OSC_HZ;
  localparam int unsigned BOOST_CYCLES = (BOOST_CYC_RAW < 1) ? 1 : int'(BOOST_CYC_RAW);
  localparam longint unsigned RST_CYC_RAW =
    (RESET_MACHINE_CYCLES * OSC_PER_MACHINE_CYCLE * CLK_HZ + OSC_HZ - 1) / OSC_HZ;
  localparam int unsigned RESET_CYCLES = (RST_CYC_RAW < 1) ? 1 : int'(RST_CYC_RAW);

  // ----------------------------------------------------------------
  // Port selection and latch update operations
  // ----------------------------------------------------------------
  typedef enum logic {
    QBP_PORT3,
    QBP_PORT4
  } qbp_port_e;

  typedef enum logic [3:0] {
    QBP_OP_AND,
    QBP_OP_OR,
    QBP_OP_XOR,
    QBP_OP_INC,
    QBP_OP_DEC,
    QBP_OP_BIT_CLR,
    QBP_OP_BIT_SET,
    QBP_OP_BIT_CPL,
    QBP_OP_BIT_MOV
  } qbp_rmw_e;

endpackage

`default_nettype wire

// *** core/qbp_sync.sv ***
/*
  Two-flop synchroniser for a vector of asynchronous levels.
  Assumes one clock, synchronous active-low reset, idle level given as a
  parameter.
*/
`timescale 1ns/10ps
`default_nettype none

module qbp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } qbp_sync_s;

  qbp_sync_s st_q;
  qbp_sync_s st_d;

  always_comb begin
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '{meta: IDLE, stable: IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule // qbp_sync

`default_nettype wire

// *** core/qbp_port.sv ***
/*
  Quasi-bidirectional third and fourth ports: latches, CPU strobes, latch
  based read-modify-write, alternate function routing, strong pull-up boost,
  device reset qualification and first-port pull-up control.
  Assumes pins are open drain with a pull-up outside; peripherals idle their
  alternate outputs high; the CPU issues one strobe at a time.
*/
// Functional notes
// [RQ1] Third port: eight pins, pulled high when latch is one, usable as inputs.
// [RQ2] Fourth port: two pins, same behaviour as the third port.
// [RQ3] Third-port alternate functions need latch one, except serial transmit and write strobe.
// [RQ4] Third port bits: rx, tx, two irq/gate, two timer counts, write strobe, one plain.
// [RQ5] Fourth port: bit 0 CAN transmit, bit 1 CAN receive gated by latch.
// [RQ6] Reset pin high for two machine cycles resets the device.
// [RQ7] Write-latch strobe loads the internal data bus into the latch.
// [RQ8] Read-latch strobe returns the latch contents, not the pins.
// [RQ9] Read-pin strobe returns the sampled pin levels.
// [RQ10] Every line is input or output independently of the others.
// [RQ11] Software writes one to use a pin as input; pull-down then released.
// [RQ12] With latch one, the alternate output decides the pin level.
// [RQ13] Read-modify-write operations on a port read the latch, not the pins.
// [RQ14] Bit operations read the whole latch, change one bit, write the byte.
// [RQ15] First-port pull-up is disconnected when the pin is an analog input.
// [RQ16] Any reset loads ones into every latch.
// [RQ17] Latch changes at end of operation; pin drive follows the next cycle.
// [RQ18] Strong pull-up for two oscillator periods after latch rise, never in reset.
// [RQ19] Pin levels pass a two-stage synchroniser before use.
// [RQ20] Pull-down equals not (latch and alternate output), with bypass overrides.
`timescale 1ns/10ps
`default_nettype none

module qbp_port #(
  parameter int unsigned BOOST_CYC = qbp_pkg::BOOST_CYCLES,
  parameter int unsigned RESET_CYC = qbp_pkg::RESET_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Reset pin and device reset
  input wire logic RST_PIN,
  output logic DEV_RESET,
  // CPU strobes and internal bus
  input wire qbp_pkg::qbp_port_e PORT_SEL,
  input wire logic WR_LATCH,
  input wire logic [qbp_pkg::BUS_W-1:0] WR_DATA,
  input wire logic RD_LATCH,
  input wire logic RD_PIN,
  input wire logic RMW_STB,
  input wire qbp_pkg::qbp_rmw_e RMW_OP,
  input wire logic [qbp_pkg::BUS_W-1:0] RMW_ARG,
  input wire logic [2:0] RMW_BIT,
  input wire logic RMW_CARRY,
  output logic [qbp_pkg::BUS_W-1:0] RD_DATA,
  output logic RD_VALID,
  // Third port pins, open drain
  input wire logic [qbp_pkg::P3_W-1:0] P3_PIN_I,
  output logic [qbp_pkg::P3_W-1:0] P3_PIN_O,
  output logic [qbp_pkg::P3_W-1:0] P3_PIN_OE,
  output logic [qbp_pkg::P3_W-1:0] P3_BOOST,
  // Fourth port pins, open drain
  input wire logic [qbp_pkg::P4_W-1:0] P4_PIN_I,
  output logic [qbp_pkg::P4_W-1:0] P4_PIN_O,
  output logic [qbp_pkg::P4_W-1:0] P4_PIN_OE,
  output logic [qbp_pkg::P4_W-1:0] P4_BOOST,
  // Alternate outputs from peripherals
  input wire logic [qbp_pkg::P3_W-1:0] ALT3_OUT,
  input wire logic EXT_WR_EN,
  input wire logic CAN_TX_OUT,
  // Alternate inputs to peripherals
  output logic SER_RX_IN,
  output logic EXT_IRQ_ZERO_IN,
  output logic EXT_IRQ_ONE_IN,
  output logic TMR_ZERO_COUNT_IN,
  output logic TMR_ONE_COUNT_IN,
  output logic CAN_RX_IN,
  // First port pull-up control
  input wire logic [qbp_pkg::BUS_W-1:0] P1_ANALOG_SEL,
  output logic [qbp_pkg::BUS_W-1:0] P1_PULLUP_EN
);

  localparam int unsigned CW = $clog2(BOOST_CYC + 1);
  localparam int unsigned RW = $clog2(RESET_CYC + 1);
  localparam int unsigned SW = qbp_pkg::P3_W + qbp_pkg::P4_W + 1;
  localparam logic [CW-1:0] BOOST_LOAD = CW'(BOOST_CYC);
  localparam logic [RW-1:0] RESET_DONE = RW'(RESET_CYC);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [qbp_pkg::P3_W-1:0] lat3;
    logic [qbp_pkg::P4_W-1:0] lat4;
    logic [qbp_pkg::P3_W-1:0] prev3;
    logic [qbp_pkg::P4_W-1:0] prev4;
    logic [qbp_pkg::P3_W-1:0][CW-1:0] cnt3;
    logic [qbp_pkg::P4_W-1:0][CW-1:0] cnt4;
    logic [qbp_pkg::P3_W-1:0] boost3;
    logic [qbp_pkg::P4_W-1:0] boost4;
    logic [qbp_pkg::P3_W-1:0] pd3;
    logic [qbp_pkg::P4_W-1:0] pd4;
    logic [RW-1:0] rst_cnt;
    logic dev_rst;
    logic [qbp_pkg::BUS_W-1:0] rd_data;
    logic rd_valid;
    logic [5:0] alt_in;
    logic [qbp_pkg::BUS_W-1:0] pu1;
  } qbp_port_s;

  localparam qbp_port_s ST_RST = '{
    lat3: qbp_pkg::P3_LATCH_RST,
    lat4: qbp_pkg::P4_LATCH_RST,
    prev3: qbp_pkg::P3_LATCH_RST,
    prev4: qbp_pkg::P4_LATCH_RST,
    alt_in: '1,
    pu1: '1,
    default: '0
  };

  qbp_port_s st_q;
  qbp_port_s st_d;
  logic [SW-1:0] pins_s;
  logic [qbp_pkg::P3_W-1:0] pin3_s;
  logic [qbp_pkg::P4_W-1:0] pin4_s;
  logic rst_pin_s;
  logic [qbp_pkg::BUS_W-1:0] old_byte;
  logic [qbp_pkg::BUS_W-1:0] new_byte;
  logic [qbp_pkg::P3_W-1:0] rise3;
  logic [qbp_pkg::P4_W-1:0] rise4;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  qbp_sync #(
    .W(SW),
    .IDLE({1'b0, {(SW-1){1'b1}}})
  ) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .async_in({RST_PIN, P4_PIN_I, P3_PIN_I}), // [RQ19]
    .sync_out(pins_s)
  );

  assign pin3_s = pins_s[qbp_pkg::P3_W-1:0];
  assign pin4_s = pins_s[qbp_pkg::P3_W +: qbp_pkg::P4_W];
  assign rst_pin_s = pins_s[SW-1];

  // ----------------------------------------------------------------
  // Latch update for read-modify-write
  // ----------------------------------------------------------------
  function automatic logic [qbp_pkg::BUS_W-1:0] rmw_calc(
    input qbp_pkg::qbp_rmw_e op,
    input logic [qbp_pkg::BUS_W-1:0] old,
    input logic [qbp_pkg::BUS_W-1:0] arg,
    input logic [2:0] bsel,
    input logic carry
  );
    logic [qbp_pkg::BUS_W-1:0] res;
    res = old;
    unique case (op)
      qbp_pkg::QBP_OP_AND: res = old & arg;
      qbp_pkg::QBP_OP_OR: res = old | arg;
      qbp_pkg::QBP_OP_XOR: res = old ^ arg;
      qbp_pkg::QBP_OP_INC: res = old + 8'h01;
      qbp_pkg::QBP_OP_DEC: res = old - 8'h01;
      qbp_pkg::QBP_OP_BIT_CLR: res[bsel] = 1'b0; // [RQ14]
      qbp_pkg::QBP_OP_BIT_SET: res[bsel] = 1'b1; // [RQ14]
      qbp_pkg::QBP_OP_BIT_CPL: res[bsel] = ~old[bsel]; // [RQ14]
      qbp_pkg::QBP_OP_BIT_MOV: res[bsel] = carry; // [RQ14]
      default: res = old;
    endcase
    return res;
  endfunction

  // Source is always the latch of the selected port
  assign old_byte = (PORT_SEL == qbp_pkg::QBP_PORT3) ? st_q.lat3
                  : {{(qbp_pkg::BUS_W-qbp_pkg::P4_W){1'b0}}, st_q.lat4}; // [RQ13]
  assign new_byte = rmw_calc(RMW_OP, old_byte, RMW_ARG, RMW_BIT, RMW_CARRY);

  assign rise3 = st_q.lat3 & ~st_q.prev3;
  assign rise4 = st_q.lat4 & ~st_q.prev4;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // Reset pin qualification
    if (rst_pin_s) begin
      if (st_q.rst_cnt != RESET_DONE) begin
        st_d.rst_cnt = st_q.rst_cnt + RW'(1);
      end
    end else begin
      st_d.rst_cnt = '0;
    end
    st_d.dev_rst = rst_pin_s && (st_d.rst_cnt == RESET_DONE); // [RQ6]

    // CPU access; each bit stands alone in the latch
    st_d.rd_valid = RD_LATCH || RD_PIN || RMW_STB;
    if (WR_LATCH) begin
      if (PORT_SEL == qbp_pkg::QBP_PORT3) begin
        st_d.lat3 = WR_DATA; // [RQ7] [RQ10] [RQ11]
      end else begin
        st_d.lat4 = WR_DATA[qbp_pkg::P4_W-1:0]; // [RQ7]
      end
    end else if (RMW_STB) begin
      if (PORT_SEL == qbp_pkg::QBP_PORT3) begin
        st_d.lat3 = new_byte; // [RQ13] [RQ14]
      end else begin
        st_d.lat4 = new_byte[qbp_pkg::P4_W-1:0]; // [RQ13]
      end
    end
    if (RD_PIN) begin
      st_d.rd_data = (PORT_SEL == qbp_pkg::QBP_PORT3) ? pin3_s
                   : {{(qbp_pkg::BUS_W-qbp_pkg::P4_W){1'b0}}, pin4_s}; // [RQ9]
    end else if (RD_LATCH || RMW_STB) begin
      st_d.rd_data = old_byte; // [RQ8]
    end else begin
      st_d.rd_data = qbp_pkg::BUS_ZERO;
    end

    // Pin drive follows the registered latch one cycle later
    st_d.prev3 = st_q.lat3;
    st_d.prev4 = st_q.lat4;
    st_d.pd3 = ~(st_q.lat3 & ALT3_OUT); // [RQ1] [RQ12] [RQ17] [RQ20]
    st_d.pd3[qbp_pkg::P3_SER_TX_BIT] = ~ALT3_OUT[qbp_pkg::P3_SER_TX_BIT]; // [RQ3] [RQ20]
    if (EXT_WR_EN) begin
      st_d.pd3[qbp_pkg::P3_EXT_WR_BIT] = ~ALT3_OUT[qbp_pkg::P3_EXT_WR_BIT]; // [RQ3] [RQ20]
    end
    st_d.pd4 = ~st_q.lat4; // [RQ2]
    st_d.pd4[qbp_pkg::P4_CAN_TX_BIT] =
      ~(st_q.lat4[qbp_pkg::P4_CAN_TX_BIT] & CAN_TX_OUT); // [RQ5] [RQ12]

    // Strong pull-up after each latch rise
    for (int i = 0; i < qbp_pkg::P3_W; i++) begin
      if (rise3[i]) begin
        st_d.cnt3[i] = BOOST_LOAD; // [RQ18]
      end else if (st_q.cnt3[i] != '0) begin
        st_d.cnt3[i] = st_q.cnt3[i] - CW'(1);
      end
      st_d.boost3[i] = (st_d.cnt3[i] != '0);
    end
    for (int i = 0; i < qbp_pkg::P4_W; i++) begin
      if (rise4[i]) begin
        st_d.cnt4[i] = BOOST_LOAD; // [RQ18]
      end else if (st_q.cnt4[i] != '0) begin
        st_d.cnt4[i] = st_q.cnt4[i] - CW'(1);
      end
      st_d.boost4[i] = (st_d.cnt4[i] != '0);
    end

    // Alternate inputs, gated by their latch bits
    st_d.alt_in[0] = ~st_q.lat3[qbp_pkg::P3_SER_RX_BIT] | pin3_s[qbp_pkg::P3_SER_RX_BIT]; // [RQ3] [RQ4]
    st_d.alt_in[1] = ~st_q.lat3[qbp_pkg::P3_IRQ0_BIT] | pin3_s[qbp_pkg::P3_IRQ0_BIT]; // [RQ4]
    st_d.alt_in[2] = ~st_q.lat3[qbp_pkg::P3_IRQ1_BIT] | pin3_s[qbp_pkg::P3_IRQ1_BIT]; // [RQ4]
    st_d.alt_in[3] = ~st_q.lat3[qbp_pkg::P3_TMR0_BIT] | pin3_s[qbp_pkg::P3_TMR0_BIT]; // [RQ4]
    st_d.alt_in[4] = ~st_q.lat3[qbp_pkg::P3_TMR1_BIT] | pin3_s[qbp_pkg::P3_TMR1_BIT]; // [RQ4]
    st_d.alt_in[5] = ~st_q.lat4[qbp_pkg::P4_CAN_RX_BIT] | pin4_s[qbp_pkg::P4_CAN_RX_BIT]; // [RQ5]

    st_d.pu1 = ~P1_ANALOG_SEL; // [RQ15]

    // Device reset: ones in the latches, no boost
    if (st_q.dev_rst) begin
      st_d = ST_RST; // [RQ16] [RQ18]
      st_d.rst_cnt = st_q.rst_cnt;
      st_d.dev_rst = st_d.rst_cnt == RESET_DONE && rst_pin_s;
      st_d.pu1 = ~P1_ANALOG_SEL;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q <= ST_RST; // [RQ16]
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DEV_RESET = st_q.dev_rst;
  assign RD_DATA = st_q.rd_data;
  assign RD_VALID = st_q.rd_valid;
  assign P3_PIN_O = '0;
  assign P3_PIN_OE = st_q.pd3;
  assign P3_BOOST = st_q.boost3;
  assign P4_PIN_O = '0;
  assign P4_PIN_OE = st_q.pd4;
  assign P4_BOOST = st_q.boost4;
  assign SER_RX_IN = st_q.alt_in[0];
  assign EXT_IRQ_ZERO_IN = st_q.alt_in[1];
  assign EXT_IRQ_ONE_IN = st_q.alt_in[2];
  assign TMR_ZERO_COUNT_IN = st_q.alt_in[3];
  assign TMR_ONE_COUNT_IN = st_q.alt_in[4];
  assign CAN_RX_IN = st_q.alt_in[5];
  assign P1_PULLUP_EN = st_q.pu1;

endmodule // qbp_port

`default_nettype wire

// *** bench/qbp_port_properties.sv ***
/*
  Checks on the port block reads, pins, boost, pull-ups and device reset.
  Assumes it is bound to the port block top.
*/
`timescale 1ns/10ps
`default_nettype none

module qbp_port_properties #(
  parameter int unsigned RESET_CYC = 24
) (
  // Clock and resets
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic RST_PIN,
  input wire logic DEV_RESET,
  // CPU side
  input wire qbp_pkg::qbp_port_e PORT_SEL,
  input wire logic RD_LATCH,
  input wire logic RD_PIN,
  input wire logic RMW_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic RD_VALID,
  // Pins
  input wire logic [7:0] P3_PIN_O,
  input wire logic [7:0] P3_PIN_OE,
  input wire logic [7:0] P3_BOOST,
  input wire logic [1:0] P4_BOOST,
  input wire logic [7:0] ALT3_OUT,
  input wire logic [7:0] P1_ANALOG_SEL,
  input wire logic [7:0] P1_PULLUP_EN
);
  // ----------------------------------------
  // Reset pin high time
  // ----------------------------------------
  logic [15:0] hi_q;
  always_ff @(posedge CLK) begin
    if (!RST_PIN) begin
      hi_q <= 16'h0000;
    end else if (hi_q != 16'hffff) begin
      hi_q <= hi_q + 16'h0001;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_taken;
    (RD_LATCH || RD_PIN || RMW_STB) && !DEV_RESET;
  endsequence
  sequence s_pin_drop;
    $fell(RST_PIN);
  endsequence

  rd_answer_a: assert property (s_taken |=> RD_VALID)
    else $error("read answer missing");
  rd_idle_a: assert property (!RD_VALID |-> RD_DATA == 8'h00)
    else $error("read data not idle");
  p4_width_a: assert property (RD_VALID && $past(PORT_SEL) == qbp_pkg::QBP_PORT4 |-> RD_DATA[7:2] == 6'h00)
    else $error("fourth port read too wide");
  tx_bypass_a: assert property (!DEV_RESET |=> P3_PIN_OE[1] == !$past(ALT3_OUT[1]))
    else $error("serial transmit not bypassing latch");
  boost_hold_a: assert property ($rose(P3_BOOST[0]) && !DEV_RESET |=> P3_BOOST[0])
    else $error("boost too short");
  boost_edge_a: assert property ($rose(P3_BOOST[0]) && $past(ALT3_OUT[0]) |-> $fell(P3_PIN_OE[0]))
    else $error("boost not at release");
  boost_reset_a: assert property (disable iff (1'b0) !RESETN || DEV_RESET |=> P3_BOOST == 8'h00 && P4_BOOST == 2'h0)
    else $error("boost during reset");
  pullup_cut_a: assert property (!DEV_RESET |=> P1_PULLUP_EN == ~$past(P1_ANALOG_SEL))
    else $error("pull-up not following analog select");
  dev_on_a: assert property (hi_q > RESET_CYC + 3 |-> DEV_RESET)
    else $error("device reset missing");
  dev_off_a: assert property (s_pin_drop |-> ##[1:4] !DEV_RESET)
    else $error("device reset stuck");
  drain_only_a: assert property (P3_PIN_O == 8'h00)
    else $error("pin driven high");
endmodule // qbp_port_properties

bind qbp_port qbp_port_properties #(.RESET_CYC(RESET_CYC)) u_props (.CLK, .RESETN, .RST_PIN, .DEV_RESET,
  .PORT_SEL, .RD_LATCH, .RD_PIN, .RMW_STB, .RD_DATA, .RD_VALID, .P3_PIN_O, .P3_PIN_OE, .P3_BOOST,
  .P4_BOOST, .ALT3_OUT, .P1_ANALOG_SEL, .P1_PULLUP_EN);

`default_nettype wire

// *** bench/qbp_pin_model.sv ***
/*
  Pins with pull-ups, the port pull-downs and loads that pull low.
  Assumes a high enable from the port pulls the pin low.
*/
`timescale 1ns/10ps
`default_nettype none

module qbp_pin_model #(
  parameter int DLY = 0
) (
  // Port drive and loads
  input wire logic [7:0] oe3,
  input wire logic [1:0] oe4,
  input wire logic [7:0] low3,
  input wire logic [1:0] low4,
  // Pin levels
  output logic [7:0] pin3,
  output logic [1:0] pin4
);
  // Released lines rise through the pull-up
  assign #(DLY) pin3 = ~(oe3 | low3);
  assign #(DLY) pin4 = ~(oe4 | low4);
endmodule // qbp_pin_model

`default_nettype wire

// *** bench/tb_quasi_bidir_port_latch.sv ***
/*
  Self-checking bench: CPU strobes, alternate outputs and pin loads
  against a latch model.
  Assumes the pin model and the checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_quasi_bidir_port_latch;
  logic CLK, RESETN, RST_PIN, WR_LATCH, RD_LATCH, RD_PIN, RMW_STB, RMW_CARRY, EXT_WR_EN, CAN_TX_OUT;
  logic DEV_RESET, RD_VALID, SER_RX_IN, EXT_IRQ_ZERO_IN, EXT_IRQ_ONE_IN, TMR_ZERO_COUNT_IN;
  logic TMR_ONE_COUNT_IN, CAN_RX_IN;
  qbp_pkg::qbp_port_e PORT_SEL;
  qbp_pkg::qbp_rmw_e RMW_OP;
  logic [2:0] RMW_BIT;
  logic [7:0] WR_DATA, RMW_ARG, RD_DATA, P3_PIN_I, P3_PIN_O, P3_PIN_OE, P3_BOOST, ALT3_OUT;
  logic [7:0] P1_ANALOG_SEL, P1_PULLUP_EN, low3;
  logic [1:0] P4_PIN_I, P4_PIN_O, P4_PIN_OE, P4_BOOST, low4;
  logic [15:0] lf;
  logic [8:0] r;
  int n_fail, tests_run, cycles, old;
  int lat[2];
  wire logic [5:0] alt_in = {TMR_ONE_COUNT_IN, TMR_ZERO_COUNT_IN, EXT_IRQ_ONE_IN, EXT_IRQ_ZERO_IN,
    SER_RX_IN, CAN_RX_IN};

  qbp_port #(.BOOST_CYC(2), .RESET_CYC(4)) dut (.CLK, .RESETN, .RST_PIN, .DEV_RESET, .PORT_SEL,
    .WR_LATCH, .WR_DATA, .RD_LATCH, .RD_PIN, .RMW_STB, .RMW_OP, .RMW_ARG, .RMW_BIT, .RMW_CARRY,
    .RD_DATA, .RD_VALID, .P3_PIN_I, .P3_PIN_O, .P3_PIN_OE, .P3_BOOST, .P4_PIN_I, .P4_PIN_O,
    .P4_PIN_OE, .P4_BOOST, .ALT3_OUT, .EXT_WR_EN, .CAN_TX_OUT, .SER_RX_IN, .EXT_IRQ_ZERO_IN,
    .EXT_IRQ_ONE_IN, .TMR_ZERO_COUNT_IN, .TMR_ONE_COUNT_IN, .CAN_RX_IN, .P1_ANALOG_SEL, .P1_PULLUP_EN);
  qbp_pin_model #(.DLY(7)) pins (.oe3(P3_PIN_OE), .oe4(P4_PIN_OE), .low3, .low4, .pin3(P3_PIN_I),
    .pin4(P4_PIN_I));

  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int rmw(int o, int v, int a, int b, int c, int n);
    case (o)
      0: v = v & a;
      1: v = v | a;
      2: v = v ^ a;
      3: v = v + 1;
      4: v = v - 1;
      5: v = v & ~(1 << b);
      6: v = v | (1 << b);
      7: v = v ^ (1 << b);
      default: v = c ? v | (1 << b) : v & ~(1 << b);
    endcase
    return v & ((1 << n) - 1);
  endfunction

  task automatic chk(input logic [15:0] g, input int e);
    tests_run++;
    if (g !== 16'(e)) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, 16'(e));
    end
  endtask

  // Idle wait; drops any strobe left up by the last access
  task automatic wt(input int n);
    {WR_LATCH, RD_LATCH, RD_PIN, RMW_STB} = 4'h0;
    repeat (n) @(negedge CLK);
  endtask

  // Strobes {write, read latch, read pin, rmw}; result taken one cycle on
  // Strobes stay up until the next access or wait sets them
  task automatic cyc(input logic [3:0] s, input logic p, input logic [7:0] d);
    PORT_SEL = qbp_pkg::qbp_port_e'(p);
    {WR_LATCH, RD_LATCH, RD_PIN, RMW_STB} = s;
    WR_DATA = d;
    RMW_ARG = d;
    @(negedge CLK);
    r = {RD_VALID, RD_DATA};
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {RESETN, RST_PIN, RMW_CARRY, EXT_WR_EN} = 4'h0;
    {RMW_BIT, WR_DATA, RMW_ARG, P1_ANALOG_SEL, low3, low4} = 37'h0;
    {ALT3_OUT, CAN_TX_OUT} = 9'h1ff;
    PORT_SEL = qbp_pkg::QBP_PORT3;
    RMW_OP = qbp_pkg::QBP_OP_AND;
    // Seed 15077
    lf = 16'h3ae5;
    wt(12);
    RESETN = 1'b1;
    cyc(4'h4, 0, 8'h00);
    chk(16'(r), 16'h01ff);
    cyc(4'h4, 1, 8'h00);
    chk(16'(r), 16'h0103);
    chk(16'({P3_PIN_OE, P4_PIN_OE}), 0);
    chk(16'({P3_PIN_O, P4_PIN_O}), 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      cyc(4'h8, i[0], lf[7:0]);
      lat[i % 2] = lf[7:0] & (i[0] ? 3 : 255);
      cyc(4'h4, i[0], 8'h00);
      chk(16'(r), 256 + lat[i % 2]);
    end
    $display("test write done");
    // Third-port pins held low so a pin read would differ from the latch
    low3 = 8'hff;
    for (int p = 0; p < 2; p++) begin
      for (int o = 0; o < 9; o++) begin
        lf = nx(lf);
        RMW_OP = qbp_pkg::qbp_rmw_e'(o);
        RMW_BIT = p ? {2'h0, lf[8]} : lf[10:8];
        RMW_CARRY = lf[11];
        old = lat[p];
        cyc(4'h1, p[0], lf[7:0]);
        lat[p] = rmw(o, old, lf[7:0], RMW_BIT, RMW_CARRY, p ? 2 : 8);
        chk(16'(r), 256 + old);
        cyc(4'h4, p[0], 8'h00);
        chk(16'(r), 256 + lat[p]);
      end
    end
    $display("test rmw done");
    cyc(4'h8, 0, 8'hff);
    low3 = lf[7:0];
    wt(4);
    cyc(4'h2, 0, 8'h00);
    chk(16'(r), {8'h01, ~lf[7:0]});
    low3 = 8'h00;
    cyc(4'h8, 0, lf[15:8]);
    wt(4);
    cyc(4'h2, 0, 8'h00);
    chk(16'(r), {8'h01, lf[15:8] | 8'h02});
    cyc(4'h4, 0, 8'h00);
    chk(16'(r), {8'h01, lf[15:8]});
    cyc(4'h8, 0, 8'hff);
    cyc(4'h8, 1, 8'h03);
    ALT3_OUT = 8'hfe;
    CAN_TX_OUT = 1'b0;
    wt(4);
    cyc(4'h2, 0, 8'h00);
    chk(16'(r), 16'h01fe);
    cyc(4'h2, 1, 8'h00);
    chk(16'(r), 16'h0102);
    {ALT3_OUT, CAN_TX_OUT, EXT_WR_EN} = 10'h3ff;
    cyc(4'h8, 0, 8'h00);
    wt(4);
    cyc(4'h2, 0, 8'h00);
    chk(16'(r), 16'h0142);
    EXT_WR_EN = 1'b0;
    $display("test pins done");
    cyc(4'h8, 0, 8'hff);
    {low3, low4} = 10'h052;
    wt(5);
    chk(16'(alt_in), 16'h002a);
    cyc(4'h8, 0, 8'h00);
    cyc(4'h8, 1, 8'h00);
    wt(5);
    chk(16'(alt_in), 16'h003f);
    {low3, low4} = 10'h000;
    $display("test alternate done");
    cyc(4'h8, 0, 8'hff);
    chk(16'(P3_PIN_OE), 16'h00fd);
    cyc(4'h8, 1, 8'h03);
    chk(16'({P3_BOOST, P3_PIN_OE}), 16'hff00);
    wt(1);
    chk(16'({P3_BOOST, P4_BOOST}), 16'h03ff);
    wt(1);
    chk(16'({P3_BOOST, P4_BOOST}), 16'h0003);
    wt(1);
    chk(16'({P3_BOOST, P4_BOOST}), 0);
    $display("test boost done");
    cyc(4'h8, 0, 8'h00);
    RST_PIN = 1'b1;
    wt(5);
    chk(16'(DEV_RESET), 0);
    wt(5);
    chk(16'(DEV_RESET), 1);
    RST_PIN = 1'b0;
    wt(5);
    cyc(4'h4, 0, 8'h00);
    chk(16'({DEV_RESET, r}), 16'h01ff);
    lf = nx(lf);
    P1_ANALOG_SEL = lf[7:0];
    wt(2);
    chk(16'(P1_PULLUP_EN), {8'h00, ~lf[7:0]});
    $display("test device reset done");
    end_of_test();
  end
endmodule // tb_quasi_bidir_port_latch

`default_nettype wire
